/* File: isgb_pkg.sv */
package isgb_pkg;
  // clock and reference rates
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned REF_HZ      = 10_000_000;
  localparam int unsigned REF_DIV     = CLK_HZ / REF_HZ;
  localparam int unsigned REF_DIV_W   = 3;
  // gate window, counted in reference ticks
  localparam int unsigned GATE_TIME_US   = 100_000;
  localparam int unsigned GATE_REF_TICKS = (REF_HZ / 1_000_000) * GATE_TIME_US;
  localparam int unsigned GATE_W         = 20;
  // calibration tap, half period in reference ticks
  localparam int unsigned CAL_HZ         = 1_000_000;
  localparam int unsigned CAL_HALF_TICKS = REF_HZ / CAL_HZ / 2;
  localparam int unsigned CAL_W          = 3;
  // presence timeout
  localparam int unsigned PRES_TIME_US   = 100;
  localparam int unsigned PRES_CYCLES    = (CLK_HZ / 1_000_000) * PRES_TIME_US;
  localparam int unsigned PRES_W         = 13;
  // register map
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_MAIN   = 8'h08;
  localparam logic [7:0] ADR_OFFSET = 8'h0C;
  localparam int unsigned CTRL_BLANK_DIS = 0;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam int unsigned ST_MODE_DISP   = 0;
  localparam int unsigned ST_MIX_PRES    = 1;
  localparam int unsigned ST_TUNE_PRES   = 2;
  localparam int unsigned ST_BEAT_PRES   = 3;
  localparam int unsigned ST_CABLE       = 4;
  localparam int unsigned ST_GATE        = 5;
  localparam int unsigned ST_BLANK       = 6;
  localparam int unsigned ST_OVERRIDE    = 7;
  localparam int unsigned CNT_W          = 24;
  typedef enum logic [0:0] {
    ISGB_GATE_SHUT = 1'b0,
    ISGB_GATE_OPEN = 1'b1
  } isgb_gate_t;
endpackage : isgb_pkg

/* File: isgb_divider.sv */
`timescale 1ns/100ps
module isgb_divider #(
  parameter int unsigned LIMIT = 4,
  parameter int unsigned W     = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic en_i,
  output logic      tick_o
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (en_i) begin
        if (cnt == W'(LIMIT - 1)) begin
          cnt    <= '0;
          tick_o <= 1'b1;
        end else begin
          cnt <= cnt + W'(1);
        end
      end
    end
  end
endmodule : isgb_divider

/* File: isgb_input.sv */
`timescale 1ns/100ps
module isgb_input (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      pulse_o,
  output logic      present_o
);
  logic                         s1;
  logic                         s2;
  logic                         s3;
  logic [isgb_pkg::PRES_W-1:0]  idle;

  // s1 feeds s2 only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // change taken once s2 and s3 agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= 1'b0;
      if (s2 == s3) begin
        level_o <= s3;
        pulse_o <= s3 & ~level_o;
      end
    end
  end

  // present while edges keep arriving
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle      <= isgb_pkg::PRES_W'(isgb_pkg::PRES_CYCLES);
      present_o <= 1'b0;
    end else begin
      if (pulse_o) begin
        idle <= '0;
      end else if (idle != isgb_pkg::PRES_W'(isgb_pkg::PRES_CYCLES)) begin
        idle <= idle + isgb_pkg::PRES_W'(1);
      end
      present_o <= (idle != isgb_pkg::PRES_W'(isgb_pkg::PRES_CYCLES));
    end
  end
endmodule : isgb_input

/* File: isgb_top.sv */
`timescale 1ns/100ps
module isgb_top #(
  parameter int unsigned GATE_REF_TICKS = isgb_pkg::GATE_REF_TICKS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        mode_display_i,
  input  wire logic        mix_osc_input_i,
  input  wire logic        measured_input_i,
  input  wire logic        tuning_osc_input_i,
  input  wire logic        beat_offset_input_i,
  input  wire logic        offset_mix_pulse_i,
  input  wire logic        cal_cable_i,
  input  wire logic        blank_override_switch_i,
  output logic             main_pulse_o,
  output logic             offset_pulse_o,
  output logic             gate_o,
  output logic             digit_wrap_nine_o,
  output logic             digit_zero_reset_o,
  output logic             cal_tap_o,
  output logic             display_off_n_o
);
  logic                          mode_disp;
  logic                          mix_pulse;
  logic                          mix_pres;
  logic                          meas_pulse;
  logic                          tune_pres;
  logic                          beat_pres;
  logic                          offs_pulse;
  logic                          cable;
  logic                          override_sw;
  logic                          ref_tick;
  logic                          gate_tick;
  logic                          cal_tick;
  isgb_pkg::isgb_gate_t          gate;
  logic                          cal_level;
  logic                          blank;
  logic                          blank_dis;
  logic [isgb_pkg::CNT_W-1:0]    main_cnt;
  logic [isgb_pkg::CNT_W-1:0]    offs_cnt;
  logic [isgb_pkg::CNT_W-1:0]    main_last;
  logic [isgb_pkg::CNT_W-1:0]    offs_last;
  logic                          absent;
  logic                          next_blank;
  logic                          sel_pulse;
  logic                          wb_hit;
  logic [31:0]                   next_rdata;

  isgb_input u_mode (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .pin_i     (mode_display_i),
    .level_o   (mode_disp),
    .pulse_o   (),
    .present_o ()
  );

  isgb_input u_mix (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .pin_i     (mix_osc_input_i),
    .level_o   (),
    .pulse_o   (mix_pulse),
    .present_o (mix_pres)
  );

  isgb_input u_meas (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .pin_i     (measured_input_i),
    .level_o   (),
    .pulse_o   (meas_pulse),
    .present_o ()
  );

  isgb_input u_tune (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .pin_i     (tuning_osc_input_i),
    .level_o   (),
    .pulse_o   (),
    .present_o (tune_pres)
  );

  isgb_input u_beat (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .pin_i     (beat_offset_input_i),
    .level_o   (),
    .pulse_o   (),
    .present_o (beat_pres)
  );

  isgb_input u_offs (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .pin_i     (offset_mix_pulse_i),
    .level_o   (),
    .pulse_o   (offs_pulse),
    .present_o ()
  );

  isgb_input u_cable (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .pin_i     (cal_cable_i),
    .level_o   (cable),
    .pulse_o   (),
    .present_o ()
  );

  isgb_input u_ovr (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .pin_i     (blank_override_switch_i),
    .level_o   (override_sw),
    .pulse_o   (),
    .present_o ()
  );

  // 10 MHz reference tick from the system clock
  isgb_divider #(
    .LIMIT (isgb_pkg::REF_DIV),
    .W     (isgb_pkg::REF_DIV_W)
  ) u_ref (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .en_i   (1'b1),
    .tick_o (ref_tick)
  );

  isgb_divider #(
    .LIMIT (GATE_REF_TICKS),
    .W     (isgb_pkg::GATE_W)
  ) u_gate (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .en_i   (ref_tick),
    .tick_o (gate_tick)
  );

  // divide by ten, half each level
  isgb_divider #(
    .LIMIT (isgb_pkg::CAL_HALF_TICKS),
    .W     (isgb_pkg::CAL_W)
  ) u_cal (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .en_i   (ref_tick),
    .tick_o (cal_tick)
  );

  // gate alternates open and shut, equal halves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate <= isgb_pkg::ISGB_GATE_SHUT;
    end else if (gate_tick) begin
      unique case (gate)
        isgb_pkg::ISGB_GATE_SHUT: gate <= isgb_pkg::ISGB_GATE_OPEN;
        isgb_pkg::ISGB_GATE_OPEN: gate <= isgb_pkg::ISGB_GATE_SHUT;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_o <= 1'b0;
    end else begin
      gate_o <= (gate == isgb_pkg::ISGB_GATE_OPEN);
    end
  end

  always_comb begin
    sel_pulse = mode_disp ? mix_pulse : meas_pulse;
  end

  // pulses faster than a quarter clock are not resolved
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_pulse_o <= 1'b0;
    end else begin
      main_pulse_o <= (gate == isgb_pkg::ISGB_GATE_OPEN) & sel_pulse;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      offset_pulse_o <= 1'b0;
    end else begin
      offset_pulse_o <= (gate == isgb_pkg::ISGB_GATE_OPEN) & mode_disp
                        & beat_pres & offs_pulse;
    end
  end

  // digit wrap mode follows display mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      digit_wrap_nine_o <= 1'b0;
    end else begin
      digit_wrap_nine_o <= mode_disp;
    end
  end

  // zero reset at gate opening, counter mode only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      digit_zero_reset_o <= 1'b0;
    end else begin
      digit_zero_reset_o <= gate_tick & ~mode_disp
                            & (gate == isgb_pkg::ISGB_GATE_SHUT);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_level <= 1'b0;
    end else if (cal_tick) begin
      cal_level <= ~cal_level;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_tap_o <= 1'b0;
    end else begin
      cal_tap_o <= cable & cal_level;
    end
  end

  always_comb begin
    absent = ~mix_pres | ~tune_pres;
  end

  always_comb begin
    next_blank = absent & mode_disp & ~override_sw & ~blank_dis;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blank           <= 1'b0;
      display_off_n_o <= 1'b1;
    end else begin
      blank           <= next_blank;
      display_off_n_o <= ~next_blank;
    end
  end

  // pulse tallies latched as each window shuts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_cnt  <= '0;
      offs_cnt  <= '0;
      main_last <= '0;
      offs_last <= '0;
    end else if (gate_tick & (gate == isgb_pkg::ISGB_GATE_OPEN)) begin
      main_last <= main_cnt + isgb_pkg::CNT_W'(main_pulse_o);
      offs_last <= offs_cnt + isgb_pkg::CNT_W'(offset_pulse_o);
      main_cnt  <= '0;
      offs_cnt  <= '0;
    end else begin
      main_cnt <= main_cnt + isgb_pkg::CNT_W'(main_pulse_o);
      offs_cnt <= offs_cnt + isgb_pkg::CNT_W'(offset_pulse_o);
    end
  end

  // wishbone slave, ack one cycle after the strobe
  always_comb begin
    wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blank_dis <= isgb_pkg::CTRL_RESET[isgb_pkg::CTRL_BLANK_DIS];
    end else if (wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0]
                 & (wb_adr_i == isgb_pkg::ADR_CTRL)) begin
      blank_dis <= wb_dat_i[isgb_pkg::CTRL_BLANK_DIS];
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      isgb_pkg::ADR_CTRL: begin
        next_rdata[isgb_pkg::CTRL_BLANK_DIS] = blank_dis;
      end
      isgb_pkg::ADR_STATUS: begin
        next_rdata[isgb_pkg::ST_MODE_DISP] = mode_disp;
        next_rdata[isgb_pkg::ST_MIX_PRES]  = mix_pres;
        next_rdata[isgb_pkg::ST_TUNE_PRES] = tune_pres;
        next_rdata[isgb_pkg::ST_BEAT_PRES] = beat_pres;
        next_rdata[isgb_pkg::ST_CABLE]     = cable;
        next_rdata[isgb_pkg::ST_GATE]      = gate_o;
        next_rdata[isgb_pkg::ST_BLANK]     = blank;
        next_rdata[isgb_pkg::ST_OVERRIDE]  = override_sw;
      end
      isgb_pkg::ADR_MAIN: begin
        next_rdata[isgb_pkg::CNT_W-1:0] = main_last;
      end
      isgb_pkg::ADR_OFFSET: begin
        next_rdata[isgb_pkg::CNT_W-1:0] = offs_last;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // unmapped addresses still ack, reading zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit & ~wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end
endmodule : isgb_top

/* File: isgb_properties.sv */
`timescale 1ns/100ps
module isgb_properties #(
  parameter int unsigned GATE_REF_TICKS = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cal_cable_i,
  input wire logic blank_override_switch_i,
  input wire logic main_pulse_o,
  input wire logic offset_pulse_o,
  input wire logic gate_o,
  input wire logic digit_wrap_nine_o,
  input wire logic digit_zero_reset_o,
  input wire logic cal_tap_o,
  input wire logic display_off_n_o
);
  int unsigned g_len;
  logic [7:0]  cab_hi, cab_lo, ovr_hi, tap_len;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // saturating, so long idle spans never wrap
  function automatic logic [7:0] up(logic [7:0] v, logic c);
    return !c ? 8'h00 : (v == 8'hFF ? v : v + 8'h01);
  endfunction : up
  always_ff @(posedge clk_i) begin
    g_len   <= (!rst_i && gate_o) ? g_len + 1 : 0;
    cab_hi  <= up(cab_hi, !rst_i && cal_cable_i);
    cab_lo  <= up(cab_lo, !rst_i && !cal_cable_i);
    ovr_hi  <= up(ovr_hi, !rst_i && blank_override_switch_i);
    tap_len <= up(tap_len, !rst_i && cal_tap_o);
  end
  main_gated_a: assert property (
    main_pulse_o |-> gate_o || $past(gate_o))
    else $error("main pulse outside window");
  offset_gated_a: assert property (
    offset_pulse_o |-> gate_o || $past(gate_o))
    else $error("offset pulse outside window");
  offset_mode_a: assert property (
    offset_pulse_o |-> digit_wrap_nine_o || $past(digit_wrap_nine_o))
    else $error("offset pulse in counter mode");
  zero_reset_a: assert property (
    digit_zero_reset_o |-> !digit_wrap_nine_o ##1 $rose(gate_o))
    else $error("digit reset out of place");
  gate_len_a: assert property (
    $fell(gate_o) |-> g_len == 4 * GATE_REF_TICKS)
    else $error("gate window length wrong");
  cal_off_a: assert property (
    cal_tap_o |-> cab_lo < 8'd10)
    else $error("cal tap without cable");
  cal_period_a: assert property (
    $fell(cal_tap_o) && cab_hi > 8'd60 |-> tap_len == 8'd20)
    else $error("cal tap half period wrong");
  counter_unblank_a: assert property (
    !digit_wrap_nine_o && !$past(digit_wrap_nine_o, 4) |-> display_off_n_o)
    else $error("blanked in counter mode");
  override_hold_a: assert property (
    ovr_hi > 8'd10 |-> display_off_n_o)
    else $error("blanked despite override");
endmodule : isgb_properties
bind isgb_top isgb_properties #(.GATE_REF_TICKS(GATE_REF_TICKS)) i_props (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .cal_cable_i(cal_cable_i),
  .blank_override_switch_i(blank_override_switch_i),
  .main_pulse_o(main_pulse_o),
  .offset_pulse_o(offset_pulse_o),
  .gate_o(gate_o),
  .digit_wrap_nine_o(digit_wrap_nine_o),
  .digit_zero_reset_o(digit_zero_reset_o),
  .cal_tap_o(cal_tap_o),
  .display_off_n_o(display_off_n_o)
);

/* File: isgb_partner.sv */
`timescale 1ns/100ps
module isgb_partner (
  input  wire logic       clk_i,
  input  wire logic [4:0] en_i,
  output logic      [4:0] osc_o
);
  // mix, measured, tuning, beat, offset mix
  localparam int HALF [5] = '{4, 5, 3, 6, 3};
  int cnt [5];
  // a silent source stands still at low
  always @(posedge clk_i) begin
    for (int k = 0; k < 5; k++) begin
      if (!en_i[k]) begin
        cnt[k]   <= 0;
        osc_o[k] <= 1'b0;
      end else if (cnt[k] == HALF[k] - 1) begin
        cnt[k]   <= 0;
        osc_o[k] <= ~osc_o[k];
      end else begin
        cnt[k] <= cnt[k] + 1;
      end
    end
  end
endmodule : isgb_partner

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  localparam int GT = 20;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dw = 32'h0, dr, rd;
  logic        ack, mode = 1'b0, cab = 1'b0, ovr = 1'b0;
  logic [4:0]  en = 5'h00;
  logic [4:0]  osc;
  logic        wrap, tap, dofn, gate;
  logic [31:0] seed = 32'hF376B752;
  int          fail_count = 0;
  int          n_tests = 0;
  logic [31:0] k;
  isgb_partner i_partner (.clk_i(clk_i), .en_i(en), .osc_o(osc));
  isgb_top #(.GATE_REF_TICKS(GT)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .mode_display_i(mode),
    .mix_osc_input_i(osc[0]), .measured_input_i(osc[1]),
    .tuning_osc_input_i(osc[2]), .beat_offset_input_i(osc[3]),
    .offset_mix_pulse_i(osc[4]), .cal_cable_i(cab),
    .blank_override_switch_i(ovr), .main_pulse_o(), .offset_pulse_o(),
    .gate_o(gate), .digit_wrap_nine_o(wrap), .digit_zero_reset_o(),
    .cal_tap_o(tap), .display_off_n_o(dofn));
  initial forever #12.5 clk_i = ~clk_i;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  // edges of a source seen in one window, one either side
  function automatic logic near(input logic [31:0] v, input int half);
    int e;
    e = 4 * GT / (2 * half);
    return v >= e - 1 && v <= e + 1;
  endfunction : near
  task automatic wrap_up;
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dw  <= d;
    for (n = 0; n < 50 && ack !== 1'b1; n++) @(posedge clk_i);
    if (ack !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wait_gate(input int n);
    int   t;
    logic gp;
    gp = gate;
    for (t = 0; n > 0 && t < 5000; t++) begin
      @(posedge clk_i);
      if (gp === 1'b1 && gate === 1'b0) n--;
      gp = gate;
    end
    if (n > 0) begin
      fail_count++;
      wrap_up();
    end
  endtask : wait_gate
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    en    <= 5'h1F;
    wb(0, isgb_pkg::ADR_CTRL, 0, 4'hF);
    chk(rd, isgb_pkg::CTRL_RESET);
    seed = xs(seed);
    wb(1, isgb_pkg::ADR_CTRL, seed, 4'h1);
    wb(1, isgb_pkg::ADR_CTRL, ~seed, 4'h2);
    wb(0, isgb_pkg::ADR_CTRL, 0, 4'hF);
    chk(rd[0], seed[0]);
    wb(0, 8'h10, 0, 4'hF);
    chk(rd, 0);
    wb(1, isgb_pkg::ADR_CTRL, 0, 4'h1);
    for (int m = 1; m >= 0; m--) begin
      mode <= m[0];
      wait_gate(3);
      wb(0, isgb_pkg::ADR_MAIN, 0, 4'hF);
      chk(near(rd, m ? 4 : 5), 1);
      wb(0, isgb_pkg::ADR_OFFSET, 0, 4'hF);
      chk(m ? near(rd, 3) : rd == 0, 1);
      chk(wrap, m[0]);
    end
    mode <= 1'b1;
    en   <= 5'h17;
    repeat (4100) @(posedge clk_i);
    wait_gate(2);
    wb(0, isgb_pkg::ADR_OFFSET, 0, 4'hF);
    chk(rd, 0);
    chk(dofn, 1);
    en <= 5'h1B;
    repeat (4100) @(posedge clk_i);
    chk(dofn, 0);
    wb(0, isgb_pkg::ADR_STATUS, 0, 4'hF);
    chk(rd[2:0], 3'b011);
    wb(1, isgb_pkg::ADR_CTRL, 1, 4'h1);
    repeat (4) @(posedge clk_i);
    chk(dofn, 1);
    wb(1, isgb_pkg::ADR_CTRL, 0, 4'h1);
    repeat (4) @(posedge clk_i);
    chk(dofn, 0);
    ovr <= 1'b1;
    repeat (12) @(posedge clk_i);
    chk(dofn, 1);
    ovr  <= 1'b0;
    mode <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk(dofn, 1);
    k = 0;
    repeat (60) @(posedge clk_i) k += tap;
    chk(k, 0);
    cab <= 1'b1;
    repeat (20) @(posedge clk_i);
    k = 0;
    // five whole periods, so phase does not matter
    repeat (200) @(posedge clk_i) k += tap;
    chk(k, 100);
    wrap_up();
  end
endmodule : tb_top
